// ===== shared/sdram_pkg.sv
`default_nettype none

package sdram_pkg;

  localparam int BANK_W    = 2;
  localparam int ROW_W     = 12;
  localparam int COL_W     = 8;
  localparam int DATA_W    = 16;
  localparam int NUM_BANKS = 4;
  localparam int AP_BIT    = 10;   // precharge_select_line position
  localparam int ORDER_BIT = 3;    // Op-code bit: 1 = interleaved order
  localparam int BL_LSB    = 0;    // Op-code burst length field

  // Burst length codes carried in the load-mode op-code
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] BL_RESET    = BL_1;
  localparam logic       ORDER_RESET = 1'b0;
  localparam logic [8:0] LEN_1    = 9'h001;
  localparam logic [8:0] LEN_2    = 9'h002;
  localparam logic [8:0] LEN_4    = 9'h004;
  localparam logic [8:0] LEN_8    = 9'h008;
  localparam logic [8:0] LEN_PAGE = 9'h100;

  // Command code is {row strobe, column strobe, write strobe}, active low
  typedef enum logic [2:0] {
    CMD_LOAD_MODE = 3'b000,
    CMD_REFRESH   = 3'b001,
    CMD_PRECHARGE = 3'b010,
    CMD_ACTIVE    = 3'b011,
    CMD_WRITE     = 3'b100,
    CMD_READ      = 3'b101,
    CMD_TERMINATE = 3'b110,
    CMD_NOP       = 3'b111
  } cmd_e;

  typedef enum logic [1:0] {
    PWR_RUN  = 2'b00,
    PWR_DOWN = 2'b01,
    PWR_SELF = 2'b10
  } pwr_e;

  // Read word travelling through the output buffer with its byte masks
  typedef struct packed {
    logic [1:0]        mask;
    logic [DATA_W-1:0] data;
  } rd_word_s;

  typedef struct packed {
    logic [NUM_BANKS-1:0]            open;
    logic [NUM_BANKS-1:0][ROW_W-1:0] row;
    logic [2:0]                      bl;
    logic                            order;
    logic                            busy;
    logic                            wr;
    logic                            ap;
    logic [BANK_W-1:0]               bank;
    logic [COL_W-1:0]                start;
    logic [8:0]                      cnt;
    pwr_e                            pwr;
    logic [ROW_W-1:0]                rfsh_row;
    logic [DATA_W-1:0]               dout;
    logic [1:0]                      oe;
  } state_s;

endpackage : sdram_pkg

`default_nettype wire

// ===== hw/two_entry_buffer.sv
`default_nettype none

module two_entry_buffer #(
  parameter int WIDTH = 18
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] slot;
    logic [1:0]            count;
  } buf_state_s;

  buf_state_s st_reg;
  buf_state_s st_next;
  logic       push;
  logic       pop;

  // Full and empty come straight from the entry count
  assign in_ready  = (st_reg.count != 2'h2);
  assign out_valid = (st_reg.count != 2'h0);
  assign out_data  = st_reg.slot[0];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pop shifts slot 1 down first, so a push lands behind what remains
  always_comb begin
    st_next = st_reg;
    if (pop) begin
      st_next.slot[0] = st_reg.slot[1];
      st_next.count   = st_reg.count - 2'h1;
    end
    if (push) begin
      st_next.slot[st_next.count[0]] = in_data;
      st_next.count = st_next.count + 2'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : two_entry_buffer

`default_nettype wire

// ===== hw/sdram_quad_bank_command_interface.sv
`default_nettype none

module sdram_quad_bank_command_interface
  import sdram_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              clk_gate,
  input  wire logic              chip_select_n,
  input  wire logic              row_strobe_n,
  input  wire logic              column_strobe_n,
  input  wire logic              write_strobe_n,
  input  wire logic [BANK_W-1:0] bank_select,
  input  wire logic [ROW_W-1:0]  address_lines,
  input  wire logic              low_byte_mask,
  input  wire logic              high_byte_mask,
  input  wire logic [DATA_W-1:0] data_lines_in,
  input  wire logic              data_accept,
  output logic [DATA_W-1:0]      data_lines_out,
  output logic [1:0]             data_lines_oe,
  output logic [NUM_BANKS-1:0]   bank_open,
  output logic                   burst_busy,
  output pwr_e                   power_state,
  output logic [ROW_W-1:0]       refresh_row
);

  localparam int MEM_DEPTH = NUM_BANKS * (2 ** ROW_W) * (2 ** COL_W);
  localparam int IDX_W     = BANK_W + ROW_W + COL_W;

  ////////////////////////////////////////////////////////////////////////////
  // Burst helpers

  function automatic logic [8:0] blen_of(input logic [2:0] bl);
    unique case (bl)
      BL_1:    return LEN_1;
      BL_2:    return LEN_2;
      BL_4:    return LEN_4;
      BL_8:    return LEN_8;
      default: return LEN_PAGE;  // Unused codes take the full-page length of 256 beats
    endcase
  endfunction : blen_of

  // Column for beat n; the block wraps inside its length-aligned window
  function automatic logic [COL_W-1:0] col_of(
    input logic [COL_W-1:0] start,
    input logic [8:0]       n,
    input logic [2:0]       bl,
    input logic             order
  );
    logic [COL_W-1:0] m;
    logic [COL_W-1:0] lo;
    m  = COL_W'(blen_of(bl) - LEN_1);
    lo = (order && bl != BL_PAGE) ? (start ^ n[COL_W-1:0])
                                  : (start + n[COL_W-1:0]);
    return (start & ~m) | (lo & m);
  endfunction : col_of

  ////////////////////////////////////////////////////////////////////////////
  // State, memory and buffer

  state_s            st_reg;
  state_s            st_next;
  logic [DATA_W-1:0] mem [MEM_DEPTH];
  cmd_e              cmd;
  logic              run;
  logic              cmd_ok;
  logic              acc_new;
  logic              stop;
  logic              a_active;
  logic              a_wr;
  logic              a_ap;
  logic [BANK_W-1:0] a_bank;
  logic [COL_W-1:0]  a_start;
  logic [8:0]        a_cnt;
  logic [COL_W-1:0]  col;
  logic              beat;
  logic              last;
  logic              ap_close;
  logic [IDX_W-1:0]  idx;
  rd_word_s          push_word;
  rd_word_s          pop_word;
  logic              buf_in_ready;
  logic              buf_out_valid;

  // Command code and gating by chip select and the clock gate
  assign cmd    = cmd_e'({row_strobe_n, column_strobe_n, write_strobe_n});
  assign run    = (st_reg.pwr == PWR_RUN) && clk_gate;
  assign cmd_ok = run && !chip_select_n;

  // A column command only counts against an open row
  assign acc_new = cmd_ok && (cmd == CMD_READ || cmd == CMD_WRITE)
                   && st_reg.open[bank_select];
  assign stop    = cmd_ok && (cmd == CMD_TERMINATE
                   || (cmd == CMD_PRECHARGE
                       && (address_lines[AP_BIT]
                           || bank_select == st_reg.bank)));

  // A new column command wins over the running burst; a low gate only
  // suspends it, so the burst must not be dropped here
  assign a_active = acc_new || (st_reg.busy && !stop);
  assign a_wr     = acc_new ? (cmd == CMD_WRITE) : st_reg.wr;
  assign a_ap     = acc_new ? address_lines[AP_BIT] : st_reg.ap;
  assign a_bank   = acc_new ? bank_select : st_reg.bank;
  assign a_start  = acc_new ? address_lines[COL_W-1:0] : st_reg.start;
  assign a_cnt    = acc_new ? 9'h000 : st_reg.cnt;
  assign col      = col_of(a_start, a_cnt, st_reg.bl, st_reg.order);

  // Reads wait while the buffer is full, so no word is dropped; no beat
  // steps while the clock gate is low
  assign beat     = a_active && run && (a_wr || buf_in_ready);
  assign last     = (st_reg.bl != BL_PAGE)
                    && (a_cnt + 9'h001 == blen_of(st_reg.bl));
  assign ap_close = beat && last && a_ap;
  assign idx      = {a_bank, st_reg.row[a_bank], col};

  assign push_word.mask = {high_byte_mask, low_byte_mask};
  assign push_word.data = mem[idx];

  // Read words queue here; a stall by the receiver backs up into the burst
  two_entry_buffer #(
    .WIDTH ($bits(rd_word_s))
  ) u_read_buffer (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (beat && !a_wr),
    .in_ready  (buf_in_ready),
    .in_data   (push_word),
    .out_valid (buf_out_valid),
    .out_ready (data_accept),
    .out_data  (pop_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Array write with byte lanes

  // Masked bytes keep their old contents
  always_ff @(posedge clk_sys) begin
    if (beat && a_wr) begin
      if (!low_byte_mask) begin
        mem[idx][7:0] <= data_lines_in[7:0];
      end
      if (!high_byte_mask) begin
        mem[idx][15:8] <= data_lines_in[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_next = st_reg;

    // Burst tracking
    st_next.busy  = a_active && !(beat && last);
    st_next.wr    = a_wr;
    st_next.ap    = a_ap;
    st_next.bank  = a_bank;
    st_next.start = a_start;
    st_next.cnt   = beat ? a_cnt + 9'h001 : a_cnt;

    // Bank commands; other banks stay as they are
    if (cmd_ok) begin
      unique case (cmd)
        CMD_ACTIVE: begin
          st_next.open[bank_select] = 1'b1;
          st_next.row[bank_select]  = address_lines;
        end
        CMD_PRECHARGE: begin
          if (address_lines[AP_BIT]) begin
            st_next.open = '0;
          end else begin
            st_next.open[bank_select] = 1'b0;
          end
        end
        CMD_REFRESH: begin
          st_next.rfsh_row = st_reg.rfsh_row + 12'h001;
        end
        CMD_LOAD_MODE: begin
          // Mode changes only between bursts, so counts stay consistent
          if (!st_reg.busy) begin
            st_next.bl    = address_lines[BL_LSB +: 3];
            st_next.order = address_lines[ORDER_BIT];
          end
        end
        CMD_READ, CMD_WRITE, CMD_TERMINATE, CMD_NOP: begin
        end
      endcase
    end

    // Self-timed close after the final beat
    if (ap_close) begin
      st_next.open[a_bank] = 1'b0;
    end

    // Power modes; a burst under a low gate is merely suspended
    unique case (st_reg.pwr)
      PWR_RUN: begin
        if (!clk_gate && !st_reg.busy) begin
          if (!chip_select_n && cmd == CMD_REFRESH && st_reg.open == '0) begin
            st_next.pwr = PWR_SELF;
          end else begin
            st_next.pwr = PWR_DOWN;
          end
        end
      end
      PWR_DOWN: begin
        if (clk_gate) begin
          st_next.pwr = PWR_RUN;
        end
      end
      PWR_SELF: begin
        st_next.rfsh_row = st_reg.rfsh_row + 12'h001;
        if (clk_gate) begin
          st_next.pwr = PWR_RUN;
        end
      end
      default: begin
        st_next.pwr = PWR_RUN;
      end
    endcase

    // Output stage: masked bytes float, two edges after their mask
    if (buf_out_valid && data_accept) begin
      st_next.dout = pop_word.data;
      st_next.oe   = ~pop_word.mask;
    end else begin
      st_next.oe   = 2'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg       <= '0;
      st_reg.bl    <= BL_RESET;
      st_reg.order <= ORDER_RESET;
      st_reg.pwr   <= PWR_RUN;
    end else begin
      st_reg <= st_next;
    end
  end

  assign data_lines_out = st_reg.dout;
  assign data_lines_oe  = st_reg.oe;
  assign bank_open      = st_reg.open;
  assign burst_busy     = st_reg.busy;
  assign power_state    = st_reg.pwr;
  assign refresh_row    = st_reg.rfsh_row;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_activate_opens;
    @(posedge clk_sys) disable iff (!rst_n)
    (cmd_ok && cmd == CMD_ACTIVE) |=> (bank_open[$past(bank_select)]
      && st_reg.row[$past(bank_select)] == $past(address_lines));
  endproperty
  a_activate_opens: assert property (p_activate_opens)
    else $error("activate did not open the addressed row");

  property p_other_banks_kept;
    @(posedge clk_sys) disable iff (!rst_n)
    (cmd_ok && cmd == CMD_PRECHARGE && !address_lines[AP_BIT] && !ap_close)
    |=> ((bank_open & ~(4'h1 << $past(bank_select)))
         == ($past(bank_open) & ~(4'h1 << $past(bank_select))));
  endproperty
  a_other_banks_kept: assert property (p_other_banks_kept)
    else $error("single-bank precharge disturbed another bank");

  property p_precharge_all;
    @(posedge clk_sys) disable iff (!rst_n)
    (cmd_ok && cmd == CMD_PRECHARGE && address_lines[AP_BIT])
    |=> (bank_open == 4'h0);
  endproperty
  a_precharge_all: assert property (p_precharge_all)
    else $error("precharge all left a bank open");

  property p_deselect_ignored;
    @(posedge clk_sys) disable iff (!rst_n)
    (run && chip_select_n && !st_reg.busy)
    |=> ($stable(bank_open) && $stable(st_reg.bl));
  endproperty
  a_deselect_ignored: assert property (p_deselect_ignored)
    else $error("command acted while chip select was high");

  property p_low_power_frozen;
    @(posedge clk_sys) disable iff (!rst_n)
    (st_reg.pwr != PWR_RUN) |=> $stable(bank_open) ##1 1'b1;
  endproperty
  a_low_power_frozen: assert property (p_low_power_frozen)
    else $error("bank state changed during power-down");

  property p_gate_enters_low_power;
    @(posedge clk_sys) disable iff (!rst_n)
    (st_reg.pwr == PWR_RUN && !clk_gate && !st_reg.busy)
    |=> (st_reg.pwr != PWR_RUN);
  endproperty
  a_gate_enters_low_power: assert property (p_gate_enters_low_power)
    else $error("low clock gate did not enter a low-power mode");

  property p_suspend_holds;
    @(posedge clk_sys) disable iff (!rst_n)
    (st_reg.busy && !clk_gate && st_reg.pwr == PWR_RUN)
    |=> (st_reg.busy && st_reg.cnt == $past(st_reg.cnt));
  endproperty
  a_suspend_holds: assert property (p_suspend_holds)
    else $error("burst advanced during clock suspend");

  property p_terminate_stops;
    @(posedge clk_sys) disable iff (!rst_n)
    (st_reg.busy && cmd_ok && cmd == CMD_TERMINATE) |=> !burst_busy;
  endproperty
  a_terminate_stops: assert property (p_terminate_stops)
    else $error("burst terminate did not end the burst");

  property p_count_bounded;
    @(posedge clk_sys) disable iff (!rst_n)
    (st_reg.busy && st_reg.bl != BL_PAGE) |-> (st_reg.cnt < blen_of(st_reg.bl));
  endproperty
  a_count_bounded: assert property (p_count_bounded)
    else $error("burst counter ran past the programmed length");

  property p_auto_precharge;
    @(posedge clk_sys) disable iff (!rst_n)
    (ap_close && !(cmd_ok && cmd == CMD_ACTIVE)) |=> !bank_open[$past(a_bank)];
  endproperty
  a_auto_precharge: assert property (p_auto_precharge)
    else $error("auto precharge did not close the bank");

  property p_new_column;
    @(posedge clk_sys) disable iff (!rst_n)
    (cmd_ok && cmd == CMD_READ && st_reg.open[bank_select] && buf_in_ready)
    |-> (beat && col == address_lines[COL_W-1:0]);
  endproperty
  a_new_column: assert property (p_new_column)
    else $error("column command was not taken at once");

  property p_read_mask_floats;
    @(posedge clk_sys) disable iff (!rst_n)
    (beat && !a_wr && low_byte_mask && !buf_out_valid && data_accept)
    ##1 data_accept |=> !data_lines_oe[0];
  endproperty
  a_read_mask_floats: assert property (p_read_mask_floats)
    else $error("masked read byte was driven");

  property p_read_unmasked_drives;
    @(posedge clk_sys) disable iff (!rst_n)
    (beat && !a_wr && !high_byte_mask && !buf_out_valid && data_accept)
    ##1 data_accept |=> data_lines_oe[1];
  endproperty
  a_read_unmasked_drives: assert property (p_read_unmasked_drives)
    else $error("unmasked high read byte was not driven");

endmodule : sdram_quad_bank_command_interface

`default_nettype wire

// ===== verif/sdram_host_model.sv
`default_nettype none

module sdram_host_model
  import sdram_pkg::*;
(
  input  wire logic         clk_sys,
  output logic              clk_gate,
  output logic              chip_select_n,
  output logic              row_strobe_n,
  output logic              column_strobe_n,
  output logic              write_strobe_n,
  output logic [BANK_W-1:0] bank_select,
  output logic [ROW_W-1:0]  address_lines,
  output logic              low_byte_mask,
  output logic              high_byte_mask,
  output logic [DATA_W-1:0] data_lines_in
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero: deselected, clock acting
  initial begin
    clk_gate = 1'b1;
    chip_select_n = 1'b1;
    {row_strobe_n, column_strobe_n, write_strobe_n} = CMD_NOP;
    bank_select = '0;
    address_lines = '0;
    {high_byte_mask, low_byte_mask} = 2'b00;
    data_lines_in = 16'h5A5A;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One command per cycle, driven after the falling edge so it is settled
  // around the rising edge and held a whole cycle
  task automatic cmd(input cmd_e c, input logic [1:0] b,
                     input logic [11:0] a, input logic [15:0] d,
                     input logic [1:0] m, input logic g, input logic s);
    @(negedge clk_sys);
    chip_select_n = s;
    {row_strobe_n, column_strobe_n, write_strobe_n} = c;
    bank_select = b;
    address_lines = a;
    data_lines_in = d;
    {high_byte_mask, low_byte_mask} = m;
    clk_gate = g;
  endtask : cmd

  // Idle cycles; the data bus toggles so stale data never looks valid
  task automatic idle(input int n, input logic g);
    repeat (n) cmd(CMD_NOP, 2'h0, 12'h000, ~data_lines_in, 2'b00, g, 1'b0);
  endtask : idle

endmodule : sdram_host_model

`default_nettype wire

// ===== verif/tb_top.sv
`default_nettype none

`define CHK(what, exp, got) begin check_count++; \
  if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED %s exp %h got %h", what, exp, got); end end

module tb_top
  import sdram_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0;
  logic rst_n;
  logic data_accept;
  logic clk_gate, chip_select_n, row_strobe_n, column_strobe_n;
  logic write_strobe_n, low_byte_mask, high_byte_mask;
  logic [BANK_W-1:0]    bank_select;
  logic [ROW_W-1:0]     address_lines, refresh_row, r;
  logic [DATA_W-1:0]    data_lines_in, data_lines_out;
  logic [1:0]           data_lines_oe;
  logic [NUM_BANKS-1:0] bank_open;
  logic                 burst_busy;
  pwr_e                 power_state;
  logic [17:0]          rq[$];
  int                   miscompares = 0;
  int                   check_count = 0;
  int                   n4, n8;

  always #20 clk_sys = ~clk_sys;

  sdram_host_model ctl (.clk_sys(clk_sys), .clk_gate(clk_gate),
    .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n), .write_strobe_n(write_strobe_n),
    .bank_select(bank_select), .address_lines(address_lines),
    .low_byte_mask(low_byte_mask), .high_byte_mask(high_byte_mask),
    .data_lines_in(data_lines_in));

  sdram_quad_bank_command_interface uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .clk_gate(clk_gate), .chip_select_n(chip_select_n),
    .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
    .write_strobe_n(write_strobe_n), .bank_select(bank_select),
    .address_lines(address_lines), .low_byte_mask(low_byte_mask),
    .high_byte_mask(high_byte_mask), .data_lines_in(data_lines_in),
    .data_accept(data_accept), .data_lines_out(data_lines_out),
    .data_lines_oe(data_lines_oe), .bank_open(bank_open),
    .burst_busy(burst_busy), .power_state(power_state),
    .refresh_row(refresh_row));

  ////////////////////////////////////////////////////////////////////////////
  // Collect every word the read path drives at least one byte of, in order
  always @(posedge clk_sys) begin
    if (data_lines_oe !== 2'b00) rq.push_back({data_lines_oe, data_lines_out});
  end

  task automatic give_verdict;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic lmode(input logic [2:0] code);
    ctl.cmd(CMD_LOAD_MODE, 2'h0, {9'h000, code}, 16'h0000, 2'b00, 1'b1, 1'b0);
  endtask : lmode

  // Write burst on bank 0; counts cycles seen busy
  task automatic wr_burst(input logic [7:0] col, input logic [15:0] base,
                          input int len, input logic ap, output int nb);
    nb = 0;
    ctl.cmd(CMD_WRITE, 2'h0, {1'b0, ap, 2'b00, col}, base, 2'b00, 1'b1, 1'b0);
    for (int i = 1; i < len; i++) begin
      ctl.cmd(CMD_NOP, 2'h0, 12'h000, base + 16'(i), 2'b00, 1'b1, 1'b0);
      nb += int'(burst_busy);
    end
    repeat (12) begin
      ctl.idle(1, 1'b1);
      nb += int'(burst_busy);
    end
  endtask : wr_burst

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    `CHK("bank_open", 4'h0, bank_open)
    `CHK("burst_busy", 1'b0, burst_busy)
    `CHK("power_state", PWR_RUN, power_state)
    `CHK("data_lines_oe", 2'b00, data_lines_oe)
  endtask : t_reset

  // Deselected commands do nothing; banks open one by one, close singly and all at once
  task automatic t_select;
    ctl.cmd(CMD_ACTIVE, 2'h2, 12'h005, 16'h0000, 2'b00, 1'b1, 1'b1);
    ctl.idle(1, 1'b1);
    `CHK("open deselected", 4'h0, bank_open)
    ctl.cmd(CMD_ACTIVE, 2'h2, 12'hFFF, 16'h0000, 2'b00, 1'b1, 1'b0);
    ctl.cmd(CMD_ACTIVE, 2'h1, 12'h007, 16'h0000, 2'b00, 1'b1, 1'b0);
    ctl.idle(1, 1'b1);
    `CHK("open two", 4'h6, bank_open)
    ctl.cmd(CMD_PRECHARGE, 2'h2, 12'h000, 16'h0000, 2'b00, 1'b1, 1'b0);
    ctl.cmd(CMD_ACTIVE, 2'h3, 12'h001, 16'h0000, 2'b00, 1'b1, 1'b0);
    ctl.idle(1, 1'b1);
    `CHK("close one", 4'hA, bank_open)
    ctl.cmd(CMD_PRECHARGE, 2'h0, 12'h400, 16'h0000, 2'b00, 1'b1, 1'b0);
    ctl.idle(1, 1'b1);
    `CHK("close all", 4'h0, bank_open)
  endtask : t_select

  // Masked write keeps the old byte; masked read floats two clocks on
  task automatic t_mask;
    lmode(BL_1);
    ctl.cmd(CMD_ACTIVE, 2'h1, 12'h007, 16'h0000, 2'b00, 1'b1, 1'b0);
    ctl.cmd(CMD_WRITE, 2'h1, 12'h008, 16'h1234, 2'b00, 1'b1, 1'b0);
    ctl.cmd(CMD_WRITE, 2'h1, 12'h008, 16'hABCD, 2'b01, 1'b1, 1'b0);
    ctl.cmd(CMD_READ, 2'h1, 12'h008, 16'h0000, 2'b00, 1'b1, 1'b0);
    ctl.cmd(CMD_READ, 2'h1, 12'h008, 16'h0000, 2'b10, 1'b1, 1'b0);
    `CHK("oe early", 2'b00, data_lines_oe)
    ctl.idle(1, 1'b1);
    `CHK("oe full", 2'b11, data_lines_oe)
    `CHK("masked write", 16'hAB34, data_lines_out)
    ctl.idle(1, 1'b1);
    `CHK("oe masked", 2'b01, data_lines_oe)
    `CHK("low byte", 8'h34, data_lines_out[7:0])
    ctl.idle(2, 1'b1);
    // Lone read with the low byte masked, into an empty buffer
    ctl.cmd(CMD_READ, 2'h1, 12'h008, 16'h0000, 2'b01, 1'b1, 1'b0);
    ctl.idle(2, 1'b1);
    `CHK("oe low masked", 2'b10, data_lines_oe)
    `CHK("high byte", 8'hAB, data_lines_out[15:8])
    ctl.idle(2, 1'b1);
  endtask : t_mask

  // Burst lengths, column stepping, stalled reads, terminate, auto close
  task automatic t_burst;
    lmode(BL_4);
    ctl.cmd(CMD_ACTIVE, 2'h0, 12'h003, 16'h0000, 2'b00, 1'b1, 1'b0);
    wr_burst(8'h04, 16'h1000, 4, 1'b0, n4);
    lmode(BL_8);
    wr_burst(8'h08, 16'h2000, 8, 1'b0, n8);
    `CHK("busy span", 4, n8 - n4)
    data_accept = 1'b0;
    rq.delete();
    // Starts mid-block so the burst wraps inside its eight-column window
    ctl.cmd(CMD_READ, 2'h0, 12'h00C, 16'h0000, 2'b00, 1'b1, 1'b0);
    ctl.idle(10, 1'b1);
    `CHK("stalled words", 0, rq.size())
    data_accept = 1'b1;
    ctl.idle(14, 1'b1);
    `CHK("words", 8, rq.size())
    for (int i = 0; i < 8; i++) begin
      `CHK("word", 16'h2000 + 16'((i + 4) % 8), rq[i][15:0])
    end
    rq.delete();
    ctl.cmd(CMD_READ, 2'h0, 12'h004, 16'h0000, 2'b00, 1'b1, 1'b0);
    ctl.cmd(CMD_TERMINATE, 2'h0, 12'h000, 16'h0000, 2'b00, 1'b1, 1'b0);
    ctl.idle(12, 1'b1);
    `CHK("cut short", 1'b1, rq.size() < 8)
    `CHK("first word", 16'h1000, rq[0][15:0])
    wr_burst(8'h10, 16'h3000, 8, 1'b1, n8);
    `CHK("auto close", 4'h2, bank_open)
  endtask : t_burst

  // A low gate mid-burst suspends it; every word still arrives
  task automatic t_suspend;
    rq.delete();
    ctl.cmd(CMD_READ, 2'h1, 12'h008, 16'h0000, 2'b00, 1'b1, 1'b0);
    ctl.idle(2, 1'b0);
    `CHK("suspend busy", 1'b1, burst_busy)
    `CHK("suspend run", PWR_RUN, power_state)
    ctl.idle(14, 1'b1);
    `CHK("suspend words", 8, rq.size())
    `CHK("suspend first", 16'hAB34, rq[0][15:0])
  endtask : t_suspend

  // Power-down, exit cycle ignored, auto and self refresh
  task automatic t_power;
    ctl.idle(2, 1'b0);
    `CHK("power down", PWR_DOWN, power_state)
    ctl.cmd(CMD_ACTIVE, 2'h2, 12'h005, 16'h0000, 2'b00, 1'b1, 1'b0);
    ctl.idle(1, 1'b1);
    `CHK("exit run", PWR_RUN, power_state)
    `CHK("exit ignored", 4'h2, bank_open)
    ctl.cmd(CMD_PRECHARGE, 2'h0, 12'h400, 16'h0000, 2'b00, 1'b1, 1'b0);
    r = refresh_row;
    ctl.cmd(CMD_REFRESH, 2'h0, 12'h000, 16'h0000, 2'b00, 1'b1, 1'b0);
    ctl.idle(1, 1'b1);
    `CHK("refresh step", r + 12'h001, refresh_row)
    ctl.cmd(CMD_REFRESH, 2'h0, 12'h000, 16'h0000, 2'b00, 1'b0, 1'b0);
    ctl.idle(4, 1'b0);
    `CHK("self refresh", PWR_SELF, power_state)
    ctl.idle(2, 1'b1);
    `CHK("self exit", PWR_RUN, power_state)
  endtask : t_power

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the roughly 160 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    give_verdict();
  end

  initial begin
    rst_n = 1'b0;
    data_accept = 1'b1;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset();
    t_select();
    t_mask();
    t_burst();
    t_suspend();
    t_power();
    give_verdict();
  end

endmodule : tb_top

`default_nettype wire
